// [verilog/rfk_pkg.sv]
// package for the radio kill control block: timing constants and states
// assumes a single 40 MHz core clock
package rfk_pkg;
  localparam int unsigned RFK_CLK_HZ = 40000000;
  localparam int unsigned RFK_GRACE_MS = 100;
  localparam int unsigned RFK_GRACE_CYCLES = RFK_CLK_HZ / 1000 * RFK_GRACE_MS;
  localparam int unsigned RFK_CNT_W = 23;
  localparam int unsigned RFK_SYNC_STAGES = 2;
  localparam logic RFK_KILL_ASSERTED = 1'b0;
  localparam logic RFK_SYNC_RESET = 1'b1;
  localparam logic [RFK_CNT_W-1:0] RFK_CNT_ZERO = 23'h000000;
  localparam logic [RFK_CNT_W-1:0] RFK_CNT_ONE = 23'h000001;

  typedef enum logic [1:0] {
    RFK_ST_RUN = 2'b00,
    RFK_ST_GRACE = 2'b01,
    RFK_ST_KILLED = 2'b10
  } rfk_state_t;
endpackage : rfk_pkg

// [verilog/rfk_ctrl.sv]
// radio kill control: synchronises the kill pin and gates the transmit amplifier
// assumes kill_n has a pull-up at the pad and is debounced by the platform
`timescale 1ns/1ps

// What this block does
// - low kill input disables radio, high permits operation.
// - kill input is asynchronous; synchronise it before use.
// - kill assertion shuts the amplifier in hardware, no software needed.
// - floating kill input reads high via pull-up, radio permitted.
// - deasserted kill allows transmit, subject to software enable.
// - transmission stops within one second of kill assertion.
// - shutdown deadline is met by logic alone, firmware independent.
// - radio resumes within one second of release if software allows.
// - transmit enable is software enable AND kill deasserted AND working state resumed.
// - outside full working state, radio stays off until resumed and kill clear.
// - firmware asleep at kill assertion means amplifier off immediately.
// - firmware running means about 100 ms hardware grace before forced off.
// - after power-up radio stays off until the radio-on command arrives.
module rfk_ctrl
  import rfk_pkg::*;
#(
  parameter logic [RFK_CNT_W-1:0] GRACE_CYCLES = RFK_CNT_W'(RFK_GRACE_CYCLES)
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic kill_n,
  input wire logic radio_on_cmd,
  input wire logic radio_shutdown_cmd,
  input wire logic fw_awake,
  input wire logic sys_working,
  output logic kill_level_q,
  output logic pa_enable_q,
  output logic tx_enable_q,
  output logic grace_active_q
);

  logic [RFK_SYNC_STAGES-1:0] sync_q;
  logic kill_s;
  logic sw_en_q;
  logic resume_ok_q;
  rfk_state_t state_q;
  logic [RFK_CNT_W-1:0] cnt_q;
  logic sw_en_d;
  logic resume_ok_d;
  rfk_state_t state_d;
  logic [RFK_CNT_W-1:0] cnt_d;
  logic grace_active_d;
  logic pa_enable_d;
  logic tx_enable_d;

  // grace ends on the last count, or at once if the firmware has gone to sleep
  function automatic logic grace_expired(input logic [RFK_CNT_W-1:0] cnt, input logic awake);
    return !awake || (cnt <= RFK_CNT_ONE);
  endfunction : grace_expired

  // the radio may run only with software on and the system fully awake
  function automatic logic radio_permit(input logic sw_on, input logic resumed,
    input logic working);
    return sw_on && resumed && working;
  endfunction : radio_permit

  // stage 0 is read only by stage 1; reset high so a kill is not invented
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_q <= {RFK_SYNC_STAGES{RFK_SYNC_RESET}};
    end else begin
      sync_q <= {sync_q[RFK_SYNC_STAGES-2:0], kill_n};
    end
  end

  assign kill_s = (sync_q[RFK_SYNC_STAGES-1] == RFK_KILL_ASSERTED);

  // readable copy of the pin level for software polling
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      kill_level_q <= RFK_SYNC_RESET;
    end else begin
      kill_level_q <= sync_q[RFK_SYNC_STAGES-1];
    end
  end

  // software enable: off at reset, on only after radio-on, shutdown wins
  always_comb begin
    sw_en_d = sw_en_q;
    if (radio_shutdown_cmd) begin
      sw_en_d = 1'b0;
    end else if (radio_on_cmd) begin
      sw_en_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sw_en_q <= 1'b0;
    end else begin
      sw_en_q <= sw_en_d;
    end
  end

  // once the system leaves working state, hold off until it is back with kill clear
  always_comb begin
    resume_ok_d = resume_ok_q;
    if (!sys_working) begin
      resume_ok_d = 1'b0;
    end else if (!kill_s) begin
      resume_ok_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      resume_ok_q <= 1'b0;
    end else begin
      resume_ok_q <= resume_ok_d;
    end
  end

  // kill handling: grace only when firmware is awake to wind down itself
  always_comb begin
    state_d = state_q;
    case (state_q)
      RFK_ST_RUN: begin
        if (kill_s && fw_awake) begin
          state_d = RFK_ST_GRACE;
        end else if (kill_s) begin
          state_d = RFK_ST_KILLED;
        end else begin
          state_d = RFK_ST_RUN;
        end
      end
      RFK_ST_GRACE: begin
        if (!kill_s) begin
          state_d = RFK_ST_RUN;
        end else if (grace_expired(cnt_q, fw_awake)) begin
          state_d = RFK_ST_KILLED;
        end else begin
          state_d = RFK_ST_GRACE;
        end
      end
      RFK_ST_KILLED: begin
        if (!kill_s) begin
          state_d = RFK_ST_RUN;
        end else begin
          state_d = RFK_ST_KILLED;
        end
      end
      default: begin
        // an illegal code fails safe with the amplifier off
        state_d = RFK_ST_KILLED;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= RFK_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // counter loads on grace entry and counts only while the grace holds
  always_comb begin
    cnt_d = cnt_q;
    case (state_q)
      RFK_ST_RUN: begin
        if (kill_s && fw_awake) begin
          cnt_d = GRACE_CYCLES;
        end
      end
      RFK_ST_GRACE: begin
        if (!kill_s) begin
          cnt_d = cnt_q;
        end else if (grace_expired(cnt_q, fw_awake)) begin
          cnt_d = RFK_CNT_ZERO;
        end else begin
          cnt_d = cnt_q - RFK_CNT_ONE;
        end
      end
      RFK_ST_KILLED: begin
        cnt_d = RFK_CNT_ZERO;
      end
      default: begin
        cnt_d = RFK_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= RFK_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_comb begin
    if (state_q == RFK_ST_GRACE) begin
      grace_active_d = 1'b1;
    end else begin
      grace_active_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      grace_active_q <= 1'b0;
    end else begin
      grace_active_q <= grace_active_d;
    end
  end

  // amplifier follows the hardware path only; no firmware in this loop
  always_comb begin
    if (state_q == RFK_ST_KILLED) begin
      pa_enable_d = 1'b0;
    end else begin
      pa_enable_d = radio_permit(sw_en_q, resume_ok_q, sys_working);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pa_enable_q <= 1'b0;
    end else begin
      pa_enable_q <= pa_enable_d;
    end
  end

  // transmit enable drops on the first synchronised kill sample, ahead of the amplifier
  always_comb begin
    if (kill_s) begin
      tx_enable_d = 1'b0;
    end else begin
      tx_enable_d = radio_permit(sw_en_q, resume_ok_q, sys_working);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_enable_q <= 1'b0;
    end else begin
      tx_enable_q <= tx_enable_d;
    end
  end

endmodule : rfk_ctrl

// [tb/rfk_ctrl_sva.sv]
// checker: enable and grace timing of rfk_ctrl
// assumes a short grace count in simulation, bound from the bench top
`timescale 1ns/1ps
module rfk_ctrl_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic kill_n,
  input wire logic radio_on_cmd,
  input wire logic radio_shutdown_cmd,
  input wire logic fw_awake,
  input wire logic sys_working,
  input wire logic kill_level_q,
  input wire logic pa_enable_q,
  input wire logic tx_enable_q,
  input wire logic grace_active_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_tx_kill: assert property (!kill_n [*4] |=> !tx_enable_q) else $error("tx on");
  chk_sw_off: assert property (radio_shutdown_cmd [*3] |=> !tx_enable_q) else $error("sw");
  chk_sys_off: assert property (!sys_working [*3] |=> !pa_enable_q && !tx_enable_q)
    else $error("asleep");
  chk_pa_sleep: assert property ((!kill_n && !fw_awake) [*5] |=> !pa_enable_q)
    else $error("pa late");
  chk_grace_pa: assert property (grace_active_q && $past(pa_enable_q) && $past(sys_working)
    && !$past(radio_shutdown_cmd) |-> pa_enable_q) else $error("pa");
  chk_grace_end: assert property (grace_active_q |-> ##[1:30] !grace_active_q)
    else $error("grace long");
  chk_grace_kill: assert property ($fell(grace_active_q) && !kill_level_q && fw_awake
    |-> ##[1:2] !pa_enable_q) else $error("no kill");
  chk_resume: assert property ((kill_n && sys_working && radio_on_cmd && !radio_shutdown_cmd)
    [*6] |=> tx_enable_q && pa_enable_q) else $error("no resume");
endmodule : rfk_ctrl_sva

// [tb/rfk_switch_model.sv]
// platform switch: pressed pulls the kill line low
// assumes bounce already filtered; released line rises through a pull-up
`timescale 1ns/1ps
module rfk_switch_model (
  input wire logic press,
  output wire logic kill_n
);
  // delay keeps edges off the core clock grid
  assign #7 kill_n = press ? 1'b0 : 1'b1;
endmodule : rfk_switch_model

// [tb/rfk_ctrl_tb_top.sv]
// bench for rfk_ctrl with switch model and queue scoreboard
// assumes a grace count of 20 cycles
`timescale 1ns/1ps
module rfk_ctrl_tb_top;
  logic core_clk = 1'b0, rstn = 1'b0, press = 1'b0, on = 1'b0, sd = 1'b0, fw = 1'b0, sw = 1'b1;
  wire logic kill_n, tx, pa, gr, lv;
  logic [7:0] q[$];
  logic [7:0] e;
  logic [31:0] seed = 32'h5EBB40E2;
  int err_count = 0, comparisons = 0, cyc = 0;
  event go;
  rfk_switch_model i_rfk_switch_model (.press(press), .kill_n(kill_n));
  rfk_ctrl #(.GRACE_CYCLES(23'h000014)) i_rfk_ctrl (.core_clk(core_clk), .rstn(rstn),
    .kill_n(kill_n), .radio_on_cmd(on), .radio_shutdown_cmd(sd), .fw_awake(fw),
    .sys_working(sw), .kill_level_q(lv), .pa_enable_q(pa), .tx_enable_q(tx), .grace_active_q(gr));
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // inputs {press, on, sd, fw, sw}; note {mask, tx, pa, grace, level}
  task automatic step(logic [4:0] in, int n, logic [7:0] x);
    @(posedge core_clk);
    {press, on, sd, fw, sw} <= in;
    repeat (n) @(posedge core_clk);
    #1;
    q.push_back(x);
    ->go;
  endtask : step
  task automatic chk(logic [3:0] seen, logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %b want %b", $time, seen, exp);
    end
  endtask : chk
  always @(go) begin
    e = q.pop_front();
    chk({tx, pa, gr, lv} & e[7:4], e[3:0]);
  end
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk) if (++cyc == 2000) begin
    err_count++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    step(5'b00001, 2, 8'hF1);
    step(5'b01001, 6, 8'hFD);
    step(5'b11001, 6, 8'hF0);
    step(5'b01011, 8, 8'hFD);
    step(5'b11011, 6, 8'hF6);
    step(5'b11011, 24, 8'hF0);
    step(5'b01011, 8, 8'hFD);
    step(5'b11011, 6, 8'hF6);
    step(5'b11001, 3, 8'hF0);
    step({2'b10, ~lv, 2'b01}, 4, 8'hF0);
    step(5'b01101, 8, 8'hB1);
    step(5'b01000, 6, 8'hF1);
    step(5'b01001, 6, 8'hFD);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      step({seed[0], 4'b1001}, 9, seed[0] ? 8'hF0 : 8'hFD);
    end
    report_and_stop;
  end
endmodule : rfk_ctrl_tb_top
bind rfk_ctrl rfk_ctrl_sva i_rfk_ctrl_sva (.core_clk(core_clk), .rstn(rstn), .kill_n(kill_n),
  .radio_on_cmd(radio_on_cmd), .radio_shutdown_cmd(radio_shutdown_cmd), .fw_awake(fw_awake),
  .sys_working(sys_working), .kill_level_q(kill_level_q), .pa_enable_q(pa_enable_q),
  .tx_enable_q(tx_enable_q), .grace_active_q(grace_active_q));
